// ### pkg/sadec_pkg.sv
package sadec_pkg;

    // target codes
    typedef enum logic [4:0] {
        SADEC_T_NONE      = 5'h00,
        SADEC_T_RAM       = 5'h01,
        SADEC_T_EXTREGS   = 5'h02,
        SADEC_T_CACHEREGS = 5'h03,
        SADEC_T_SER0REGS  = 5'h04,
        SADEC_T_SER1REGS  = 5'h05,
        SADEC_T_TIM0REGS  = 5'h06,
        SADEC_T_TIM1REGS  = 5'h07,
        SADEC_T_IRQSEL    = 5'h08,
        SADEC_T_DEVCFG    = 5'h09,
        SADEC_T_XFERREGS  = 5'h0A,
        SADEC_T_GPIO      = 5'h0B,
        SADEC_T_CLKMUL    = 5'h0C,
        SADEC_T_QUICK     = 5'h0D,
        SADEC_T_SER0DATA  = 5'h0E,
        SADEC_T_SER1DATA  = 5'h0F,
        SADEC_T_CE0       = 5'h10,
        SADEC_T_CE1       = 5'h11,
        SADEC_T_CE2       = 5'h12,
        SADEC_T_CE3       = 5'h13
    } sadec_target_t;

    // register slots inside a selected block
    typedef enum logic [4:0] {
        SADEC_S_NONE        = 5'h00,
        SADEC_S_EXT_GLOBAL  = 5'h01,
        SADEC_S_REGION1     = 5'h02,
        SADEC_S_REGION0     = 5'h03,
        SADEC_S_REGION2     = 5'h04,
        SADEC_S_REGION3     = 5'h05,
        SADEC_S_SDRAM_CTL   = 5'h06,
        SADEC_S_SDRAM_REF   = 5'h07,
        SADEC_S_SDRAM_EXT   = 5'h08,
        SADEC_S_CACHE_RANGE = 5'h09,
        SADEC_S_CACHE_WB    = 5'h0A,
        SADEC_S_CACHE_WBINV = 5'h0B,
        SADEC_S_MEM_ATTR    = 5'h0C,
        SADEC_S_IRQ_HIGH    = 5'h0D,
        SADEC_S_IRQ_LOW     = 5'h0E,
        SADEC_S_IRQ_POL     = 5'h0F
    } sadec_slot_t;

    // region bounds, inclusive
    localparam logic [31:0] RAM_LO   = 32'h0000_0000;
    localparam logic [31:0] RAM_HI   = 32'h0000_FFFF;
    localparam logic [31:0] EXTR_LO  = 32'h0180_0000;
    localparam logic [31:0] EXTR_HI  = 32'h0183_FFFF;
    localparam logic [31:0] CACR_LO  = 32'h0184_0000;
    localparam logic [31:0] CACR_HI  = 32'h0187_FFFF;
    localparam logic [31:0] S0R_LO   = 32'h018C_0000;
    localparam logic [31:0] S0R_HI   = 32'h018F_FFFF;
    localparam logic [31:0] S1R_LO   = 32'h0190_0000;
    localparam logic [31:0] S1R_HI   = 32'h0193_FFFF;
    localparam logic [31:0] T0R_LO   = 32'h0194_0000;
    localparam logic [31:0] T0R_HI   = 32'h0197_FFFF;
    localparam logic [31:0] T1R_LO   = 32'h0198_0000;
    localparam logic [31:0] T1R_HI   = 32'h019B_FFFF;
    localparam logic [31:0] IRQ_LO   = 32'h019C_0000;
    localparam logic [31:0] IRQ_HI   = 32'h019C_01FF;
    localparam logic [31:0] DCFG_LO  = 32'h019C_0200;
    localparam logic [31:0] DCFG_HI  = 32'h019C_0203;
    localparam logic [31:0] XFR_LO   = 32'h01A0_0000;
    localparam logic [31:0] XFR_HI   = 32'h01A3_FFFF;
    localparam logic [31:0] GPIO_LO  = 32'h01B0_0000;
    localparam logic [31:0] GPIO_HI  = 32'h01B0_3FFF;
    localparam logic [31:0] CLKM_LO  = 32'h01B7_C000;
    localparam logic [31:0] CLKM_HI  = 32'h01B7_DFFF;
    localparam logic [31:0] QCK_LO   = 32'h0200_0000;
    localparam logic [31:0] QCK_HI   = 32'h0200_0033;
    localparam logic [31:0] S0D_LO   = 32'h3000_0000;
    localparam logic [31:0] S0D_HI   = 32'h33FF_FFFF;
    localparam logic [31:0] S1D_LO   = 32'h3400_0000;
    localparam logic [31:0] S1D_HI   = 32'h37FF_FFFF;
    localparam logic [31:0] EXT_BASE = 32'h8000_0000;
    localparam logic [31:0] EXT_HI   = 32'hBFFF_FFFF;

    // external space layout
    localparam int          CE_SEL_MSB = 29;
    localparam int          CE_SEL_LSB = 28;
    localparam int          EWA_MSB    = 21;
    localparam int          EWA_LSB    = 2;

    // external-interface block offsets
    localparam logic [31:0] EXT_GLOBAL_A = 32'h0180_0000;
    localparam logic [31:0] REGION1_A    = 32'h0180_0004;
    localparam logic [31:0] REGION0_A    = 32'h0180_0008;
    localparam logic [31:0] REGION2_A    = 32'h0180_0010;
    localparam logic [31:0] REGION3_A    = 32'h0180_0014;
    localparam logic [31:0] SDRAM_CTL_A  = 32'h0180_0018;
    localparam logic [31:0] SDRAM_REF_A  = 32'h0180_001C;
    localparam logic [31:0] SDRAM_EXT_A  = 32'h0180_0020;

    // cache-control block offsets
    localparam logic [31:0] CRANGE_LO    = 32'h0184_4000;
    localparam logic [31:0] CRANGE_HI    = 32'h0184_4037;
    localparam logic [31:0] CWB_ALL_A    = 32'h0184_5000;
    localparam logic [31:0] CWBINV_ALL_A = 32'h0184_5004;
    localparam logic [31:0] MATTR_LO     = 32'h0184_8200;
    localparam logic [31:0] MATTR_HI     = 32'h0184_82CF;
    localparam int          MATTR_CE_MSB = 7;
    localparam int          MATTR_CE_LSB = 6;
    localparam int          MATTR_IX_MSB = 3;
    localparam int          MATTR_IX_LSB = 2;

    // interrupt selector offsets
    localparam logic [31:0] IRQ_HIGH_A   = 32'h019C_0000;
    localparam logic [31:0] IRQ_LOW_A    = 32'h019C_0004;
    localparam logic [31:0] IRQ_POL_A    = 32'h019C_0008;

endpackage

// ### rtl/sadec_decoder.sv
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE_01] 64K on-chip RAM at 0x00000000 to 0x0000FFFF
// [RULE_02] RAM serves instruction fetches and data alike
// [RULE_03] nothing below 0x80000000 ever goes to external memory
// [RULE_04] four 256M regions from 0x80000000; 0xC0000000 up reserved
// [RULE_05] external port drives word address lines 21..2 only
// [RULE_06] full 256MB region needs outside logic for the missing lines 27..22
// [RULE_07] external regs at 0x01800000, cache regs at 0x01840000
// [RULE_08] serial port register blocks at 0x018C0000 and 0x01900000
// [RULE_09] timer register blocks at 0x01940000 and 0x01980000
// [RULE_10] 512-byte interrupt selector region at 0x019C0000
// [RULE_11] enhanced variant only: 4-byte device config at 0x019C0200
// [RULE_12] transfer-engine RAM and registers at 0x01A00000, 256K
// [RULE_13] enhanced variant only: GPIO at 0x01B00000, clock ctrl 0x01B7C000
// [RULE_14] 52-byte quick-transfer region at 0x02000000
// [RULE_15] serial data windows at 0x30000000 and 0x34000000, 64M each
// [RULE_16] gaps are reserved and reach no target
// [RULE_17] external block slots: global, region 1,0, gap, 2,3, SDRAM trio
// [RULE_18] sixteen memory-attribute slots, four per region, 0x01848200 on
// [RULE_19] interrupt select high slot at 0x019C0000 for inputs 10..15
// [RULE_20] interrupt select low slot at 0x019C0004 for inputs 4..9
// [RULE_21] interrupt polarity slot at 0x019C0008 for external inputs 4..7
// [RULE_22] cache range pairs at 0x01844000, writeback-all 0x01845000/4
// [RULE_23] reserved access completes at once, reads zero, writes dropped
module sadec_decoder #(
    parameter bit ENHANCED = 1'b1
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // request from a bus master
    input  wire logic        i_req,
    input  wire logic        i_we,
    input  wire logic        i_fetch,
    input  wire logic [31:0] i_addr,
    // decoded answer, one cycle after the request
    output logic             o_valid,
    output logic             o_we,
    output logic             o_fetch,
    output logic [4:0]       o_target,
    output logic [4:0]       o_slot,
    output logic [3:0]       o_attr_index,
    output logic [1:0]       o_range_pair,
    output logic             o_reserved,
    output logic             o_ce_sel_n0,
    output logic [3:0]       o_ce_active,
    output logic [19:0]      o_ext_word_addr,
    output logic [31:0]      o_local_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // inclusive range check
    function automatic logic in_rng(input logic [31:0] a,
                                    input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // target decode

    sadec_pkg::sadec_target_t tgt_nxt;

    // region lookup; anything unmatched falls to none
    always_comb begin
        tgt_nxt = sadec_pkg::SADEC_T_NONE; // RULE_16
        if (in_rng(i_addr, sadec_pkg::RAM_LO, sadec_pkg::RAM_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_RAM; // RULE_01
        end else if (in_rng(i_addr, sadec_pkg::EXTR_LO, sadec_pkg::EXTR_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_EXTREGS; // RULE_07
        end else if (in_rng(i_addr, sadec_pkg::CACR_LO, sadec_pkg::CACR_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_CACHEREGS; // RULE_07
        end else if (in_rng(i_addr, sadec_pkg::S0R_LO, sadec_pkg::S0R_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_SER0REGS; // RULE_08
        end else if (in_rng(i_addr, sadec_pkg::S1R_LO, sadec_pkg::S1R_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_SER1REGS; // RULE_08
        end else if (in_rng(i_addr, sadec_pkg::T0R_LO, sadec_pkg::T0R_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_TIM0REGS; // RULE_09
        end else if (in_rng(i_addr, sadec_pkg::T1R_LO, sadec_pkg::T1R_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_TIM1REGS; // RULE_09
        end else if (in_rng(i_addr, sadec_pkg::IRQ_LO, sadec_pkg::IRQ_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_IRQSEL; // RULE_10
        end else if (ENHANCED &&
                     in_rng(i_addr, sadec_pkg::DCFG_LO, sadec_pkg::DCFG_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_DEVCFG; // RULE_11
        end else if (in_rng(i_addr, sadec_pkg::XFR_LO, sadec_pkg::XFR_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_XFERREGS; // RULE_12
        end else if (ENHANCED &&
                     in_rng(i_addr, sadec_pkg::GPIO_LO, sadec_pkg::GPIO_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_GPIO; // RULE_13
        end else if (ENHANCED &&
                     in_rng(i_addr, sadec_pkg::CLKM_LO, sadec_pkg::CLKM_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_CLKMUL; // RULE_13
        end else if (in_rng(i_addr, sadec_pkg::QCK_LO, sadec_pkg::QCK_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_QUICK; // RULE_14
        end else if (in_rng(i_addr, sadec_pkg::S0D_LO, sadec_pkg::S0D_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_SER0DATA; // RULE_15
        end else if (in_rng(i_addr, sadec_pkg::S1D_LO, sadec_pkg::S1D_HI)) begin
            tgt_nxt = sadec_pkg::SADEC_T_SER1DATA; // RULE_15
        end else if (in_rng(i_addr, sadec_pkg::EXT_BASE, sadec_pkg::EXT_HI)) begin
            // only addresses at or above the external base get here
            unique case (i_addr[sadec_pkg::CE_SEL_MSB:sadec_pkg::CE_SEL_LSB])
                2'h0: tgt_nxt = sadec_pkg::SADEC_T_CE0; // RULE_04 RULE_03
                2'h1: tgt_nxt = sadec_pkg::SADEC_T_CE1; // RULE_04
                2'h2: tgt_nxt = sadec_pkg::SADEC_T_CE2; // RULE_04
                2'h3: tgt_nxt = sadec_pkg::SADEC_T_CE3; // RULE_04
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // slot decode inside register blocks

    sadec_pkg::sadec_slot_t slot_nxt;
    logic [3:0]             attr_nxt;
    logic [1:0]             pair_nxt;

    // slot pick; only meaningful with the matching target
    always_comb begin
        slot_nxt = sadec_pkg::SADEC_S_NONE;
        attr_nxt = 4'h0;
        pair_nxt = 2'h0;
        if (tgt_nxt == sadec_pkg::SADEC_T_EXTREGS) begin
            // 0x0C stays empty between region 0 and region 2
            if (i_addr == sadec_pkg::EXT_GLOBAL_A) begin
                slot_nxt = sadec_pkg::SADEC_S_EXT_GLOBAL; // RULE_17
            end else if (i_addr == sadec_pkg::REGION1_A) begin
                slot_nxt = sadec_pkg::SADEC_S_REGION1; // RULE_17
            end else if (i_addr == sadec_pkg::REGION0_A) begin
                slot_nxt = sadec_pkg::SADEC_S_REGION0; // RULE_17
            end else if (i_addr == sadec_pkg::REGION2_A) begin
                slot_nxt = sadec_pkg::SADEC_S_REGION2; // RULE_17
            end else if (i_addr == sadec_pkg::REGION3_A) begin
                slot_nxt = sadec_pkg::SADEC_S_REGION3; // RULE_17
            end else if (i_addr == sadec_pkg::SDRAM_CTL_A) begin
                slot_nxt = sadec_pkg::SADEC_S_SDRAM_CTL; // RULE_17
            end else if (i_addr == sadec_pkg::SDRAM_REF_A) begin
                slot_nxt = sadec_pkg::SADEC_S_SDRAM_REF; // RULE_17
            end else if (i_addr == sadec_pkg::SDRAM_EXT_A) begin
                slot_nxt = sadec_pkg::SADEC_S_SDRAM_EXT; // RULE_17
            end
        end else if (tgt_nxt == sadec_pkg::SADEC_T_CACHEREGS) begin
            if (in_rng(i_addr, sadec_pkg::CRANGE_LO, sadec_pkg::CRANGE_HI)
                && (i_addr[3:2] < 2'h2)) begin
                // pairs at +0x00, +0x10, +0x20, +0x30
                slot_nxt = sadec_pkg::SADEC_S_CACHE_RANGE; // RULE_22
                pair_nxt = i_addr[5:4]; // RULE_22
            end else if (i_addr == sadec_pkg::CWB_ALL_A) begin
                slot_nxt = sadec_pkg::SADEC_S_CACHE_WB; // RULE_22
            end else if (i_addr == sadec_pkg::CWBINV_ALL_A) begin
                slot_nxt = sadec_pkg::SADEC_S_CACHE_WBINV; // RULE_22
            end else if (in_rng(i_addr, sadec_pkg::MATTR_LO,
                                sadec_pkg::MATTR_HI)
                         && (i_addr[5:4] == 2'h0)) begin
                // four words per region, region steps by 0x40
                slot_nxt = sadec_pkg::SADEC_S_MEM_ATTR; // RULE_18
                attr_nxt = {i_addr[sadec_pkg::MATTR_CE_MSB:
                                   sadec_pkg::MATTR_CE_LSB],
                            i_addr[sadec_pkg::MATTR_IX_MSB:
                                   sadec_pkg::MATTR_IX_LSB]}; // RULE_18
            end
        end else if (tgt_nxt == sadec_pkg::SADEC_T_IRQSEL) begin
            if (i_addr == sadec_pkg::IRQ_HIGH_A) begin
                slot_nxt = sadec_pkg::SADEC_S_IRQ_HIGH; // RULE_19
            end else if (i_addr == sadec_pkg::IRQ_LOW_A) begin
                slot_nxt = sadec_pkg::SADEC_S_IRQ_LOW; // RULE_20
            end else if (i_addr == sadec_pkg::IRQ_POL_A) begin
                slot_nxt = sadec_pkg::SADEC_S_IRQ_POL; // RULE_21
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered answer

    logic is_ce;
    assign is_ce = (tgt_nxt == sadec_pkg::SADEC_T_CE0) ||
                   (tgt_nxt == sadec_pkg::SADEC_T_CE1) ||
                   (tgt_nxt == sadec_pkg::SADEC_T_CE2) ||
                   (tgt_nxt == sadec_pkg::SADEC_T_CE3);

    // handshake and access kind
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_we    <= 1'b0;
            o_fetch <= 1'b0;
        end else begin
            o_valid <= i_req; // RULE_23
            o_we    <= i_req && i_we;
            o_fetch <= i_req && i_fetch; // RULE_02
        end
    end

    // target and slot
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_target     <= 5'h00;
            o_slot       <= 5'h00;
            o_attr_index <= 4'h0;
            o_range_pair <= 2'h0;
            o_reserved   <= 1'b0;
        end else if (i_req) begin
            o_target     <= tgt_nxt;
            o_slot       <= slot_nxt;
            o_attr_index <= attr_nxt;
            o_range_pair <= pair_nxt;
            o_reserved   <= (tgt_nxt == sadec_pkg::SADEC_T_NONE); // RULE_23
        end else begin
            o_target     <= 5'h00;
            o_slot       <= 5'h00;
            o_attr_index <= 4'h0;
            o_range_pair <= 2'h0;
            o_reserved   <= 1'b0;
        end
    end

    // chip enables and external word address
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ce_sel_n0     <= 1'b1;
            o_ce_active     <= 4'h0;
            o_ext_word_addr <= 20'h00000;
        end else if (i_req && is_ce) begin
            o_ce_sel_n0     <= ~(tgt_nxt == sadec_pkg::SADEC_T_CE0);
            o_ce_active     <= 4'h1 << i_addr[sadec_pkg::CE_SEL_MSB:
                                             sadec_pkg::CE_SEL_LSB]; // RULE_04
            // upper address bits are dropped; outside logic adds more
            o_ext_word_addr <= i_addr[sadec_pkg::EWA_MSB:
                                      sadec_pkg::EWA_LSB]; // RULE_05 RULE_06
        end else begin
            o_ce_sel_n0     <= 1'b1;
            o_ce_active     <= 4'h0; // RULE_03
            o_ext_word_addr <= 20'h00000;
        end
    end

    // offset within RAM, full address for other targets, zero when reserved or idle
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_local_addr <= 32'h0000_0000;
        end else if (i_req && (tgt_nxt == sadec_pkg::SADEC_T_RAM)) begin
            o_local_addr <= i_addr - sadec_pkg::RAM_LO; // RULE_01
        end else if (i_req && (tgt_nxt != sadec_pkg::SADEC_T_NONE)) begin
            o_local_addr <= i_addr;
        end else begin
            o_local_addr <= 32'h0000_0000; // RULE_23
        end
    end

endmodule

// ### testbench/sadec_decoder_chk.sv
`timescale 1ns/1ns

module sadec_decoder_chk #(
    parameter bit ENHANCED = 1'b1
) (
    // clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // request
    input wire logic        i_req,
    input wire logic        i_we,
    input wire logic        i_fetch,
    input wire logic [31:0] i_addr,
    // decoded answer
    input wire logic        o_valid,
    input wire logic        o_we,
    input wire logic        o_fetch,
    input wire logic [4:0]  o_target,
    input wire logic [4:0]  o_slot,
    input wire logic [3:0]  o_attr_index,
    input wire logic [1:0]  o_range_pair,
    input wire logic        o_reserved,
    input wire logic        o_ce_sel_n0,
    input wire logic [3:0]  o_ce_active,
    input wire logic [19:0] o_ext_word_addr,
    input wire logic [31:0] o_local_addr
);
    logic [31:0] addr_r;

    // address of the request taken at the last edge
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            addr_r <= 32'h0000_0000;
        end else begin
            addr_r <= i_addr;
        end
    end

    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////
    // answer one cycle after each request, flags copied
    property p_valid;
        i_req |=> o_valid && o_we == $past(i_we) && o_fetch == $past(i_fetch);
    endproperty
    a_valid: assert property (p_valid) else $error("no answer");

    property p_ram;
        i_req && i_addr <= sadec_pkg::RAM_HI
        |=> o_target == sadec_pkg::SADEC_T_RAM && o_local_addr == addr_r;
    endproperty
    a_ram: assert property (p_ram) else $error("ram not selected");

    property p_no_ext_low;
        i_req && !i_addr[31]
        |=> o_ce_active == 4'h0 && o_ce_sel_n0 && o_ext_word_addr == 20'h0;
    endproperty
    a_no_ext_low: assert property (p_no_ext_low) else $error("low ext");

    property p_ce_onehot;
        i_req && i_addr[31:30] == 2'b10
        |=> o_ce_active == (4'h1 << addr_r[29:28])
            && o_ce_sel_n0 == (addr_r[29:28] != 2'h0);
    endproperty
    a_ce_onehot: assert property (p_ce_onehot) else $error("bad ce");

    property p_ewa;
        i_req && i_addr[31:30] == 2'b10 |=> o_ext_word_addr == addr_r[21:2];
    endproperty
    a_ewa: assert property (p_ewa) else $error("bad word address");

    property p_top_res;
        i_req && i_addr[31:30] == 2'b11 |=> o_reserved && o_target == 5'h00
            && o_local_addr == 32'h0 && o_ce_active == 4'h0;
    endproperty
    a_top_res: assert property (p_top_res) else $error("top not reserved");

    property p_gap;
        i_req && i_addr inside {[32'h0001_0000:32'h017F_FFFF],
                                [32'h0188_0000:32'h018B_FFFF]} |=> o_reserved;
    endproperty
    a_gap: assert property (p_gap) else $error("gap not reserved");

    property p_extblk;
        i_req && i_addr inside {[sadec_pkg::EXTR_LO:sadec_pkg::EXTR_HI]}
        |=> o_target == sadec_pkg::SADEC_T_EXTREGS;
    endproperty
    a_extblk: assert property (p_extblk) else $error("ext block");

    property p_serdata;
        i_req && i_addr[31:27] == 5'b00110 |=> o_target == (addr_r[26] ?
            sadec_pkg::SADEC_T_SER1DATA : sadec_pkg::SADEC_T_SER0DATA);
    endproperty
    a_serdata: assert property (p_serdata) else $error("serial data");

    property p_irq_low;
        i_req && i_addr == sadec_pkg::IRQ_LOW_A
        |=> o_slot == sadec_pkg::SADEC_S_IRQ_LOW;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("irq low slot");

    // main scenarios reached
    c_ce: cover property (i_req && i_addr[31:30] == 2'b10);
    c_res: cover property (o_valid && o_reserved);
    c_b2b: cover property (i_req ##1 i_req);
endmodule

// ### testbench/sadec_master.sv
`timescale 1ns/1ns

module sadec_master (
    // clock
    input  wire logic        i_clk,
    // request toward the decoder
    output logic             o_req,
    output logic             o_we,
    output logic             o_fetch,
    output logic [31:0]      o_addr
);
    // bus released at start
    initial begin
        o_req   = 1'b0;
        o_we    = 1'b0;
        o_fetch = 1'b0;
        o_addr  = 32'h0000_0000;
    end

    // request placed just after a rising edge
    task automatic drive(input logic [31:0] a, input logic we, input logic f);
        @(posedge i_clk);
        o_req   <= 1'b1;
        o_we    <= we;
        o_fetch <= f;
        o_addr  <= a;
    endtask

    // released bus shows the inverse of the last values
    task automatic idle_bus();
        @(posedge i_clk);
        o_req   <= 1'b0;
        o_we    <= ~o_we;
        o_fetch <= ~o_fetch;
        o_addr  <= ~o_addr;
    endtask
endmodule

// ### testbench/system_address_decoder_tb.sv
`timescale 1ns/1ns

module system_address_decoder_tb;
    logic        i_clk, i_rst, i_req, i_we, i_fetch;
    logic        o_valid, o_we, o_fetch, o_reserved, o_ce_sel_n0;
    logic [31:0] i_addr, o_local_addr;
    logic [4:0]  o_target, o_slot;
    logic [3:0]  o_attr_index, o_ce_active;
    logic [1:0]  o_range_pair;
    logic [19:0] o_ext_word_addr;
    int          fails, n_compared;

    sadec_decoder #(.ENHANCED(1'b1)) sadec_decoder_i (.*);
    sadec_master sadec_master_i (.i_clk(i_clk), .o_req(i_req), .o_we(i_we),
        .o_fetch(i_fetch), .o_addr(i_addr));

    // clock
    always #25 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_code(input logic [4:0] got, input logic [4:0] exp);
        chk_val(32'(got), 32'(exp));
    endtask

    // one access; answer looked at in its single cycle
    task automatic exp_map(input logic [31:0] a, input logic [4:0] tgt);
        logic       ce;
        logic [3:0] one;
        ce  = (tgt >= sadec_pkg::SADEC_T_CE0);
        one = ce ? (4'h1 << a[29:28]) : 4'h0;
        sadec_master_i.drive(a, a[2], a[3]);
        sadec_master_i.idle_bus();
        @(negedge i_clk);
        chk_val(32'({o_valid, o_we, o_fetch}), 32'({1'b1, a[2], a[3]}));
        chk_code(o_target, tgt);
        chk_val(32'(o_reserved), 32'(tgt == 5'h00));
        chk_val(o_local_addr, (tgt == 5'h00) ? 32'h0 : a);
        chk_val(32'({o_ce_sel_n0, o_ce_active}), 32'({!one[0], one}));
        chk_val(32'(o_ext_word_addr), ce ? 32'(a[21:2]) : 32'h0);
    endtask

    task automatic exp_slot(input logic [31:0] a, input logic [4:0] tgt,
                            input logic [4:0] slot, input logic [3:0] aux);
        exp_map(a, tgt);
        chk_code(o_slot, slot);
        if (slot == sadec_pkg::SADEC_S_MEM_ATTR)
            chk_val(32'(o_attr_index), 32'(aux));
        if (slot == sadec_pkg::SADEC_S_CACHE_RANGE)
            chk_val(32'(o_range_pair), 32'(aux));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regions();
        exp_map(32'h0000_0008, sadec_pkg::SADEC_T_RAM);
        exp_map(32'h0000_FFF4, sadec_pkg::SADEC_T_RAM);
        exp_map(sadec_pkg::RAM_HI, sadec_pkg::SADEC_T_RAM);
        exp_map(32'h0001_0000, 5'h00);
        exp_map(32'h017F_FFFF, 5'h00);
        exp_map(sadec_pkg::CACR_HI, sadec_pkg::SADEC_T_CACHEREGS);
        exp_map(32'h0188_0000, 5'h00);
        exp_map(sadec_pkg::S0R_LO, sadec_pkg::SADEC_T_SER0REGS);
        exp_map(sadec_pkg::S1R_HI, sadec_pkg::SADEC_T_SER1REGS);
        exp_map(sadec_pkg::T0R_LO, sadec_pkg::SADEC_T_TIM0REGS);
        exp_map(sadec_pkg::T1R_HI, sadec_pkg::SADEC_T_TIM1REGS);
        exp_map(sadec_pkg::IRQ_HI, sadec_pkg::SADEC_T_IRQSEL);
        exp_map(sadec_pkg::DCFG_HI, sadec_pkg::SADEC_T_DEVCFG);
        exp_map(32'h019C_0204, 5'h00);
        exp_map(sadec_pkg::XFR_HI, sadec_pkg::SADEC_T_XFERREGS);
        exp_map(sadec_pkg::GPIO_LO, sadec_pkg::SADEC_T_GPIO);
        exp_map(sadec_pkg::CLKM_HI, sadec_pkg::SADEC_T_CLKMUL);
        exp_map(sadec_pkg::QCK_HI, sadec_pkg::SADEC_T_QUICK);
        exp_map(32'h0200_0034, 5'h00);
        exp_map(sadec_pkg::S0D_HI, sadec_pkg::SADEC_T_SER0DATA);
        exp_map(sadec_pkg::S1D_LO, sadec_pkg::SADEC_T_SER1DATA);
        exp_map(32'h7FFF_FFFF, 5'h00);
        exp_map(32'h8000_0000, sadec_pkg::SADEC_T_CE0);
        exp_map(32'h9FFF_FFFC, sadec_pkg::SADEC_T_CE1);
        exp_map(32'hA03F_FFF8, sadec_pkg::SADEC_T_CE2);
        exp_map(32'hBFFF_FFFF, sadec_pkg::SADEC_T_CE3);
        exp_map(32'hC000_0000, 5'h00);
        $display("test regions done");
    endtask

    task automatic t_slots();
        logic [4:0] xs [9];
        logic [4:0] xt = sadec_pkg::SADEC_T_EXTREGS;
        logic [4:0] ct = sadec_pkg::SADEC_T_CACHEREGS;
        logic [4:0] it = sadec_pkg::SADEC_T_IRQSEL;
        xs = '{sadec_pkg::SADEC_S_EXT_GLOBAL, sadec_pkg::SADEC_S_REGION1,
               sadec_pkg::SADEC_S_REGION0, 5'h00, sadec_pkg::SADEC_S_REGION2,
               sadec_pkg::SADEC_S_REGION3, sadec_pkg::SADEC_S_SDRAM_CTL,
               sadec_pkg::SADEC_S_SDRAM_REF, sadec_pkg::SADEC_S_SDRAM_EXT};
        for (int i = 0; i < 9; i++) begin
            exp_slot(32'h0180_0000 + 32'(4 * i), xt, xs[i], 4'h0);
        end
        for (int i = 0; i < 8; i++) begin
            exp_slot(32'h0184_4000 + 32'(16 * (i / 2) + 4 * (i % 2)), ct,
                     sadec_pkg::SADEC_S_CACHE_RANGE, 4'(i / 2));
        end
        exp_slot(32'h0184_5000, ct, sadec_pkg::SADEC_S_CACHE_WB, 4'h0);
        exp_slot(32'h0184_5004, ct, sadec_pkg::SADEC_S_CACHE_WBINV, 4'h0);
        for (int i = 0; i < 16; i++) begin
            exp_slot(32'h0184_8200 + 32'(64 * (i / 4) + 4 * (i % 4)), ct,
                     sadec_pkg::SADEC_S_MEM_ATTR, 4'(i));
        end
        exp_slot(32'h0184_82D0, ct, 5'h00, 4'h0);
        exp_slot(32'h019C_0000, it, sadec_pkg::SADEC_S_IRQ_HIGH, 4'h0);
        exp_slot(32'h019C_0004, it, sadec_pkg::SADEC_S_IRQ_LOW, 4'h0);
        exp_slot(32'h019C_0008, it, sadec_pkg::SADEC_S_IRQ_POL, 4'h0);
        $display("test slots done");
    endtask

    // back to back: chip-enable access then reserved, then idle
    task automatic t_back_to_back();
        sadec_master_i.drive(32'h9000_0010, 1'b1, 1'b0);
        sadec_master_i.drive(32'hC000_0000, 1'b1, 1'b0);
        @(negedge i_clk);
        chk_code(o_target, sadec_pkg::SADEC_T_CE1);
        chk_val(32'(o_ext_word_addr), 32'h0000_0004);
        sadec_master_i.idle_bus();
        @(negedge i_clk);
        chk_val(32'({o_valid, o_reserved, o_ce_active}), 32'h0000_0030);
        @(negedge i_clk);
        chk_val(32'({o_valid, o_ce_sel_n0}), 32'h0000_0001);
        $display("test back to back done");
    endtask

    task automatic print_verdict();
        $display("compared=%0d failed=%0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // reset, then the scenarios
    initial begin
        fails      = 0;
        n_compared = 0;
        i_clk      = 1'b0;
        i_rst      = 1'b1;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk_val(32'({o_valid, o_ce_sel_n0, o_target}), 32'h0000_0020);
        t_regions();
        t_slots();
        t_back_to_back();
        print_verdict();
    end
endmodule

bind sadec_decoder sadec_decoder_chk #(.ENHANCED(ENHANCED))
    sadec_decoder_chk_i (.*);
